// >>> shared/mcd_map.vh
// opcode classes, operand modes, lengths and cycle counts of the decoder
`ifndef MCD_MAP_VH
`define MCD_MAP_VH

// operation classes
`define MCD_OP_OTHER 5'h00
`define MCD_OP_ADD 5'h01
`define MCD_OP_ADD_WITH_CARRY 5'h02
`define MCD_OP_SUBTRACT_WITH_BORROW 5'h03
`define MCD_OP_INC 5'h04
`define MCD_OP_DEC 5'h05
`define MCD_OP_INC_DP 5'h06
`define MCD_OP_MUL 5'h07
`define MCD_OP_DIV 5'h08
`define MCD_OP_DEC_ADJ 5'h09
`define MCD_OP_AND 5'h0a
`define MCD_OP_OR 5'h0b
`define MCD_OP_XOR 5'h0c
`define MCD_OP_CLR 5'h0d
`define MCD_OP_CPL 5'h0e
`define MCD_OP_ROT_L 5'h0f
`define MCD_OP_ROT_LC 5'h10
`define MCD_OP_ROT_R 5'h11
`define MCD_OP_ROT_RC 5'h12
`define MCD_OP_SWAP 5'h13
`define MCD_OP_MOVE 5'h14
`define MCD_OP_LOAD_DP 5'h15
`define MCD_OP_EXTERNAL_DATA_MOVE 5'h16
`define MCD_OP_CODE_MEMORY_READ 5'h17
`define MCD_OP_PUSH 5'h18
`define MCD_OP_POP 5'h19
`define MCD_OP_XCH 5'h1a
`define MCD_OP_LOW_NIBBLE_EXCHANGE 5'h1b

// operand modes
`define MCD_M_NONE 3'h0
`define MCD_M_ACC 3'h1
`define MCD_M_WREG 3'h2
`define MCD_M_DIR 3'h3
`define MCD_M_IND 3'h4
`define MCD_M_IMM 3'h5
`define MCD_M_DP 3'h6
`define MCD_M_CODE 3'h7

// instruction lengths in bytes
`define MCD_LEN_1 2'h1
`define MCD_LEN_2 2'h2
`define MCD_LEN_3 2'h3

// execution times in machine cycles (one machine cycle per mclk)
`define MCD_CYC_1 3'h1
`define MCD_CYC_2 3'h2
`define MCD_CYC_4 3'h4

// field positions in the packed decode word
`define MCD_F_CLASS 15:11
`define MCD_F_LEN 10:9
`define MCD_F_CYC 8:6
`define MCD_F_SRC 5:3
`define MCD_F_DST 2:0

`endif

// >>> src/mcd_cycle_ctr.v
// machine-cycle down counter that times each decoded instruction
`timescale 1ns/100ps
`default_nettype none
module mcd_cycle_ctr #(
    parameter CW = 3
) (
    input wire mclk,
    input wire resetn,
    input wire start,
    input wire [CW-1:0] cycles,
    output reg busy_q,
    output reg done_q
);

reg [CW-1:0] cnt_q;

// load on start, count down, flag the last cycle
always @(posedge mclk)
begin
    if (!resetn)
    begin
        cnt_q <= {CW{1'b0}};
        busy_q <= 1'b0;
        done_q <= 1'b0;
    end
    else if (start)
    begin
        cnt_q <= cycles;
        busy_q <= 1'b1;
        done_q <= 1'b0;
    end
    else if (busy_q)
    begin
        cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
        // a count of one means this edge ends the instruction
        busy_q <= (cnt_q != {{(CW-1){1'b0}}, 1'b1});
        done_q <= (cnt_q == {{(CW-1){1'b0}}, 1'b1});
    end
    else
    begin
        done_q <= 1'b0;
    end
end

endmodule
`default_nettype wire

// >>> src/mcd_opcode_decoder.v
// opcode decoder: class, operand modes, length and cycle timing per opcode byte
//
// Overview of operation
// [RULE1] 28-2F, 25, 26-27, 24 decode as add without carry, one cycle
// [RULE2] 38-3F, 35, 36-37, 34 decode as add with carry, one cycle
// [RULE3] 98-9F, 95, 96-97, 94 decode as subtract with borrow, one cycle
// [RULE4] 04, 08-0F, 05, 06-07 decode as increment, one cycle
// [RULE5] A3 increments the 16-bit data pointer, one byte, two cycles
// [RULE6] 14, 18-1F, 15, 16-17 decode as decrement, one cycle
// [RULE7] AND group one cycle; 53 is three bytes, two cycles
// [RULE8] OR group one cycle; 43 is three bytes, two cycles
// [RULE9] XOR group one cycle; 63 is three bytes, two cycles
// [RULE10] 23, 33, 03, 13 are accumulator rotates, one byte, one cycle
// [RULE11] C4 swaps nibbles, E4 clears, F4 complements; one byte, one cycle
// [RULE12] E8-EF, E5, E6-E7, 74 load the accumulator in one cycle
// [RULE13] F8-FF, F5, F6-F7 store the accumulator in one cycle
// [RULE14] A8-AF and 88-8F take two cycles; 78-7F take one
// [RULE15] 85 and 75 are three bytes, two cycles
// [RULE16] 90 loads the data pointer, three bytes, two cycles
// [RULE17] E2-E3, F2-F3, E0, F0 external moves, one byte, two cycles
// [RULE18] 93 and 83 read code memory, one byte, two cycles
// [RULE19] C0 pushes and D0 pops a direct byte, two bytes, two cycles
// [RULE20] C8-CF, C5, C6-C7 exchange in one cycle; D6-D7 swap low nibble
// [RULE21] standard binary encoding with the architecture's usual function
// [RULE22] A4 and 84 take four cycles; D4 takes one
// [RULE23] low three bits pick the register, lowest bit the pointer
`timescale 1ns/100ps
`default_nettype none
`include "mcd_map.vh"
module mcd_opcode_decoder (
    input wire mclk,
    input wire resetn,
    input wire op_valid,
    input wire [7:0] op_byte,
    output wire busy_q,
    output wire done_q,
    output reg dec_valid_q,
    output reg known_q,
    output reg [4:0] op_class_q,
    output reg [1:0] op_len_q,
    output reg [2:0] op_cycles_q,
    output reg [2:0] src_mode_q,
    output reg [2:0] dst_mode_q,
    output reg [2:0] working_register_q,
    output reg indirect_pointer_register_q
);

wire take;
wire [15:0] dec_w;

// standard column layout of the arithmetic and logic rows
function [2:0] mode_of;
    input [3:0] lo;
    begin
        if (lo[3])
            mode_of = `MCD_M_WREG;
        else if (lo == 4'h5)
            mode_of = `MCD_M_DIR;
        else if (lo[3:1] == 3'h3)
            mode_of = `MCD_M_IND;
        else
            mode_of = `MCD_M_IMM;
    end
endfunction

// operand bytes follow only for direct and immediate forms
function [1:0] len_of;
    input [2:0] m;
    begin
        if (m == `MCD_M_DIR || m == `MCD_M_IMM)
            len_of = `MCD_LEN_2;
        else
            len_of = `MCD_LEN_1;
    end
endfunction

function [15:0] pack;
    input [4:0] c;
    input [1:0] l;
    input [2:0] y;
    input [2:0] s;
    input [2:0] d;
    begin
        pack = {c, l, y, s, d};
    end
endfunction

// one row of accumulator arithmetic or logic, columns 4 to f
function [15:0] acc_row;
    input [4:0] c;
    input [3:0] lo;
    begin
        acc_row = pack(c, len_of(mode_of(lo)), `MCD_CYC_1, mode_of(lo), `MCD_M_ACC);
    end
endfunction

// full opcode map; anything outside these groups is flagged unknown
function [15:0] decode;
    input [7:0] op;
    reg [3:0] hi;
    reg [3:0] lo;
    reg [2:0] m;
    begin
        hi = op[7:4];
        lo = op[3:0];
        m = mode_of(lo);
        decode = pack(`MCD_OP_OTHER, `MCD_LEN_1, `MCD_CYC_1, `MCD_M_NONE, `MCD_M_NONE);
        case (hi) // [RULE21]
            4'h0:
            begin
                if (lo == 4'h3)
                    decode = pack(`MCD_OP_ROT_R, `MCD_LEN_1, `MCD_CYC_1, `MCD_M_ACC, `MCD_M_ACC); // [RULE10]
                else if (lo == 4'h4)
                    decode = pack(`MCD_OP_INC, `MCD_LEN_1, `MCD_CYC_1, `MCD_M_ACC, `MCD_M_ACC); // [RULE4]
                else if (lo >= 4'h5)
                    decode = pack(`MCD_OP_INC, len_of(m), `MCD_CYC_1, m, m); // [RULE4]
            end
            4'h1:
            begin
                if (lo == 4'h3)
                    decode = pack(`MCD_OP_ROT_RC, `MCD_LEN_1, `MCD_CYC_1, `MCD_M_ACC, `MCD_M_ACC); // [RULE10]
                else if (lo == 4'h4)
                    decode = pack(`MCD_OP_DEC, `MCD_LEN_1, `MCD_CYC_1, `MCD_M_ACC, `MCD_M_ACC); // [RULE6]
                else if (lo >= 4'h5)
                    decode = pack(`MCD_OP_DEC, len_of(m), `MCD_CYC_1, m, m); // [RULE6]
            end
            4'h2:
            begin
                if (lo == 4'h3)
                    decode = pack(`MCD_OP_ROT_L, `MCD_LEN_1, `MCD_CYC_1, `MCD_M_ACC, `MCD_M_ACC); // [RULE10]
                else if (lo >= 4'h4)
                    decode = acc_row(`MCD_OP_ADD, lo); // [RULE1]
            end
            4'h3:
            begin
                if (lo == 4'h3)
                    decode = pack(`MCD_OP_ROT_LC, `MCD_LEN_1, `MCD_CYC_1, `MCD_M_ACC, `MCD_M_ACC); // [RULE10]
                else if (lo >= 4'h4)
                    decode = acc_row(`MCD_OP_ADD_WITH_CARRY, lo); // [RULE2]
            end
            4'h4, 4'h5, 4'h6:
            begin
                // the three logic rows share one layout
                if (lo == 4'h2)
                    decode = pack(logic_class(hi), `MCD_LEN_2, `MCD_CYC_1, `MCD_M_ACC, `MCD_M_DIR); // [RULE7] [RULE8] [RULE9]
                else if (lo == 4'h3)
                    decode = pack(logic_class(hi), `MCD_LEN_3, `MCD_CYC_2, `MCD_M_IMM, `MCD_M_DIR); // [RULE7] [RULE8] [RULE9]
                else if (lo >= 4'h4)
                    decode = acc_row(logic_class(hi), lo); // [RULE7] [RULE8] [RULE9]
            end
            4'h7:
            begin
                if (lo == 4'h4)
                    decode = pack(`MCD_OP_MOVE, `MCD_LEN_2, `MCD_CYC_1, `MCD_M_IMM, `MCD_M_ACC); // [RULE12]
                else if (lo == 4'h5)
                    decode = pack(`MCD_OP_MOVE, `MCD_LEN_3, `MCD_CYC_2, `MCD_M_IMM, `MCD_M_DIR); // [RULE15]
                else if (lo >= 4'h6)
                    decode = pack(`MCD_OP_MOVE, `MCD_LEN_2, `MCD_CYC_1, `MCD_M_IMM, m); // [RULE14]
            end
            4'h8:
            begin
                if (lo == 4'h3)
                    decode = pack(`MCD_OP_CODE_MEMORY_READ, `MCD_LEN_1, `MCD_CYC_2, `MCD_M_CODE, `MCD_M_ACC); // [RULE18]
                else if (lo == 4'h4)
                    decode = pack(`MCD_OP_DIV, `MCD_LEN_1, `MCD_CYC_4, `MCD_M_ACC, `MCD_M_ACC); // [RULE22]
                else if (lo == 4'h5)
                    decode = pack(`MCD_OP_MOVE, `MCD_LEN_3, `MCD_CYC_2, `MCD_M_DIR, `MCD_M_DIR); // [RULE15]
                else if (lo >= 4'h6)
                    decode = pack(`MCD_OP_MOVE, `MCD_LEN_2, `MCD_CYC_2, m, `MCD_M_DIR); // [RULE14]
            end
            4'h9:
            begin
                if (lo == 4'h0)
                    decode = pack(`MCD_OP_LOAD_DP, `MCD_LEN_3, `MCD_CYC_2, `MCD_M_IMM, `MCD_M_DP); // [RULE16]
                else if (lo == 4'h3)
                    decode = pack(`MCD_OP_CODE_MEMORY_READ, `MCD_LEN_1, `MCD_CYC_2, `MCD_M_CODE, `MCD_M_ACC); // [RULE18]
                else if (lo >= 4'h4)
                    decode = acc_row(`MCD_OP_SUBTRACT_WITH_BORROW, lo); // [RULE3]
            end
            4'ha:
            begin
                if (lo == 4'h3)
                    decode = pack(`MCD_OP_INC_DP, `MCD_LEN_1, `MCD_CYC_2, `MCD_M_DP, `MCD_M_DP); // [RULE5]
                else if (lo == 4'h4)
                    decode = pack(`MCD_OP_MUL, `MCD_LEN_1, `MCD_CYC_4, `MCD_M_ACC, `MCD_M_ACC); // [RULE22]
                else if (lo >= 4'h6)
                    decode = pack(`MCD_OP_MOVE, `MCD_LEN_2, `MCD_CYC_2, `MCD_M_DIR, m); // [RULE14]
            end
            4'hc:
            begin
                if (lo == 4'h0)
                    decode = pack(`MCD_OP_PUSH, `MCD_LEN_2, `MCD_CYC_2, `MCD_M_DIR, `MCD_M_NONE); // [RULE19]
                else if (lo == 4'h4)
                    decode = pack(`MCD_OP_SWAP, `MCD_LEN_1, `MCD_CYC_1, `MCD_M_ACC, `MCD_M_ACC); // [RULE11]
                else if (lo >= 4'h5)
                    decode = pack(`MCD_OP_XCH, len_of(m), `MCD_CYC_1, m, `MCD_M_ACC); // [RULE20]
            end
            4'hd:
            begin
                if (lo == 4'h0)
                    decode = pack(`MCD_OP_POP, `MCD_LEN_2, `MCD_CYC_2, `MCD_M_NONE, `MCD_M_DIR); // [RULE19]
                else if (lo == 4'h4)
                    decode = pack(`MCD_OP_DEC_ADJ, `MCD_LEN_1, `MCD_CYC_1, `MCD_M_ACC, `MCD_M_ACC); // [RULE22]
                else if (lo[3:1] == 3'h3)
                    decode = pack(`MCD_OP_LOW_NIBBLE_EXCHANGE, `MCD_LEN_1, `MCD_CYC_1, `MCD_M_IND, `MCD_M_ACC); // [RULE20]
            end
            4'he:
            begin
                if (lo == 4'h0)
                    decode = pack(`MCD_OP_EXTERNAL_DATA_MOVE, `MCD_LEN_1, `MCD_CYC_2, `MCD_M_DP, `MCD_M_ACC); // [RULE17]
                else if (lo[3:1] == 3'h1)
                    decode = pack(`MCD_OP_EXTERNAL_DATA_MOVE, `MCD_LEN_1, `MCD_CYC_2, `MCD_M_IND, `MCD_M_ACC); // [RULE17]
                else if (lo == 4'h4)
                    decode = pack(`MCD_OP_CLR, `MCD_LEN_1, `MCD_CYC_1, `MCD_M_NONE, `MCD_M_ACC); // [RULE11]
                else if (lo >= 4'h5)
                    decode = pack(`MCD_OP_MOVE, len_of(m), `MCD_CYC_1, m, `MCD_M_ACC); // [RULE12]
            end
            4'hf:
            begin
                if (lo == 4'h0)
                    decode = pack(`MCD_OP_EXTERNAL_DATA_MOVE, `MCD_LEN_1, `MCD_CYC_2, `MCD_M_ACC, `MCD_M_DP); // [RULE17]
                else if (lo[3:1] == 3'h1)
                    decode = pack(`MCD_OP_EXTERNAL_DATA_MOVE, `MCD_LEN_1, `MCD_CYC_2, `MCD_M_ACC, `MCD_M_IND); // [RULE17]
                else if (lo == 4'h4)
                    decode = pack(`MCD_OP_CPL, `MCD_LEN_1, `MCD_CYC_1, `MCD_M_ACC, `MCD_M_ACC); // [RULE11]
                else if (lo >= 4'h5)
                    decode = pack(`MCD_OP_MOVE, len_of(m), `MCD_CYC_1, `MCD_M_ACC, m); // [RULE13]
            end
            default:
            begin
                // row b holds only branch and bit opcodes
                decode = pack(`MCD_OP_OTHER, `MCD_LEN_1, `MCD_CYC_1, `MCD_M_NONE, `MCD_M_NONE);
            end
        endcase
    end
endfunction

// row 4 is or, row 5 and, row 6 exclusive-or
function [4:0] logic_class;
    input [3:0] hi;
    begin
        case (hi)
            4'h4: logic_class = `MCD_OP_OR;
            4'h5: logic_class = `MCD_OP_AND;
            default: logic_class = `MCD_OP_XOR;
        endcase
    end
endfunction

assign dec_w = decode(op_byte);
// a new opcode is only taken once the previous one has run its cycles
assign take = op_valid & ~busy_q;

// capture the decode result; fields hold until the next opcode is taken
always @(posedge mclk)
begin
    if (!resetn)
    begin
        dec_valid_q <= 1'b0;
        known_q <= 1'b0;
        op_class_q <= `MCD_OP_OTHER;
        op_len_q <= `MCD_LEN_1;
        op_cycles_q <= `MCD_CYC_1;
        src_mode_q <= `MCD_M_NONE;
        dst_mode_q <= `MCD_M_NONE;
        working_register_q <= 3'h0;
        indirect_pointer_register_q <= 1'b0;
    end
    else
    begin
        dec_valid_q <= take;
        if (take)
        begin
            known_q <= (dec_w[`MCD_F_CLASS] != `MCD_OP_OTHER);
            op_class_q <= dec_w[`MCD_F_CLASS];
            op_len_q <= dec_w[`MCD_F_LEN];
            op_cycles_q <= dec_w[`MCD_F_CYC];
            src_mode_q <= dec_w[`MCD_F_SRC];
            dst_mode_q <= dec_w[`MCD_F_DST];
            working_register_q <= op_byte[2:0]; // [RULE23]
            indirect_pointer_register_q <= op_byte[0]; // [RULE23]
        end
    end
end

// times the instruction; busy blocks new opcodes for its whole duration
mcd_cycle_ctr #(
    .CW(3)
) u_ctr (
    .mclk(mclk),
    .resetn(resetn),
    .start(take),
    .cycles(dec_w[`MCD_F_CYC]),
    .busy_q(busy_q),
    .done_q(done_q)
);

endmodule
`default_nettype wire

// >>> bench/mcd_opcode_decoder_assertions.sv
// timing and field checks watching the opcode decoder's ports
`timescale 1ns/100ps
`default_nettype none
`include "mcd_map.vh"
module mcd_chk (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic op_valid,
    input wire logic [7:0] op_byte,
    input wire logic busy_q,
    input wire logic done_q,
    input wire logic dec_valid_q,
    input wire logic known_q,
    input wire logic [4:0] op_class_q,
    input wire logic [1:0] op_len_q,
    input wire logic [2:0] op_cycles_q,
    input wire logic [2:0] src_mode_q,
    input wire logic [2:0] dst_mode_q,
    input wire logic [2:0] working_register_q,
    input wire logic indirect_pointer_register_q
);
    // one clock domain, so one default for all checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    // a take starts the answer and the busy span together
    chk_take_starts_busy: assert property (op_valid && !busy_q |=> dec_valid_q && busy_q)
        else $error("taken opcode gave no answer or no busy");
    // requests during busy must leave no trace
    chk_busy_refuses: assert property (busy_q |=> !dec_valid_q)
        else $error("opcode taken while busy");
    chk_answer_pulse: assert property (dec_valid_q |=> !dec_valid_q)
        else $error("answer strobe longer than one cycle");
    chk_done_pulse: assert property (done_q |=> !done_q)
        else $error("done longer than one cycle");
    chk_one_cycle_end: assert property (dec_valid_q && op_cycles_q == 3'h1 |=> done_q && !busy_q)
        else $error("one-cycle instruction mistimed");
    chk_two_cycle_end: assert property (dec_valid_q && op_cycles_q == 3'h2
        |-> busy_q ##1 busy_q && !done_q ##1 done_q && !busy_q)
        else $error("two-cycle instruction mistimed");
    chk_four_cycle_end: assert property (dec_valid_q && op_cycles_q == 3'h4
        |-> busy_q [*4] ##1 done_q && !busy_q)
        else $error("four-cycle instruction mistimed");
    // register fields come from the opcode that was taken
    chk_reg_select: assert property (dec_valid_q |-> working_register_q == $past(op_byte[2:0])
        && indirect_pointer_register_q == $past(op_byte[0]))
        else $error("register select does not follow opcode");
    chk_fields_hold: assert property ($past(resetn) && !dec_valid_q
        |-> $stable(op_class_q) && $stable(op_len_q) && $stable(op_cycles_q))
        else $error("decode fields changed without a take");
    chk_mul_div_four: assert property (dec_valid_q && (op_class_q == `MCD_OP_MUL
        || op_class_q == `MCD_OP_DIV) |-> op_cycles_q == 3'h4 && op_len_q == 2'h1)
        else $error("multiply or divide timing wrong");
    chk_ext_two_cycle: assert property (dec_valid_q
        && op_class_q == `MCD_OP_EXTERNAL_DATA_MOVE |-> op_cycles_q == 3'h2 && op_len_q == 2'h1)
        else $error("external move timing wrong");

    // main scenarios reached
    cov_one_cycle: cover property (dec_valid_q && op_cycles_q == 3'h1);
    cov_four_cycle: cover property (dec_valid_q && op_cycles_q == 3'h4);
    cov_refused: cover property (busy_q && op_valid);
endmodule

bind mcd_opcode_decoder mcd_chk chk_u (.mclk(mclk), .resetn(resetn), .op_valid(op_valid),
    .op_byte(op_byte), .busy_q(busy_q), .done_q(done_q), .dec_valid_q(dec_valid_q),
    .known_q(known_q), .op_class_q(op_class_q), .op_len_q(op_len_q),
    .op_cycles_q(op_cycles_q), .src_mode_q(src_mode_q), .dst_mode_q(dst_mode_q),
    .working_register_q(working_register_q),
    .indirect_pointer_register_q(indirect_pointer_register_q));
`default_nettype wire

// >>> bench/testbench.sv
// self-checking bench for the opcode decoder
`timescale 1ns/100ps
`default_nettype none
`include "mcd_map.vh"
module testbench;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic op_valid = 1'b0;
    logic [7:0] op_byte = 8'h00;
    wire busy_q, done_q, dec_valid_q, known_q, indirect_pointer_register_q;
    wire [4:0] op_class_q;
    wire [1:0] op_len_q;
    wire [2:0] op_cycles_q, src_mode_q, dst_mode_q, working_register_q;
    int fail_count = 0;
    int samples_checked = 0;

    // 100 MHz clock
    always #5 mclk = ~mclk;

    mcd_opcode_decoder dut_u (.mclk(mclk), .resetn(resetn), .op_valid(op_valid),
        .op_byte(op_byte), .busy_q(busy_q), .done_q(done_q), .dec_valid_q(dec_valid_q),
        .known_q(known_q), .op_class_q(op_class_q), .op_len_q(op_len_q),
        .op_cycles_q(op_cycles_q), .src_mode_q(src_mode_q), .dst_mode_q(dst_mode_q),
        .working_register_q(working_register_q),
        .indirect_pointer_register_q(indirect_pointer_register_q));

    task tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", samples_checked, fail_count);
            if (fail_count == 0 && samples_checked > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask

    // case equality so an unknown never matches
    task chk(input logic [7:0] got, input logic [7:0] exp);
        begin
            samples_checked++;
            if (got !== exp)
            begin
                $display("Error at %0t: got %h expected %h", $time, got, exp);
                fail_count++;
            end
        end
    endtask

    // offer one opcode at a falling edge, judge fields and the busy span
    task dec(input logic [7:0] op, input logic [4:0] c, input logic [1:0] l, input logic [2:0] n);
        int k;
        begin
            k = 0;
            op_valid = 1'b1;
            op_byte = op;
            @(negedge mclk);
            op_valid = 1'b0;
            chk({7'h0, dec_valid_q}, 8'h01);
            chk({7'h0, busy_q}, 8'h01);
            chk({3'h0, op_class_q}, {3'h0, c});
            chk({7'h0, known_q}, {7'h0, c !== `MCD_OP_OTHER});
            chk({6'h0, op_len_q}, {6'h0, l});
            chk({5'h0, op_cycles_q}, {5'h0, n});
            chk({5'h0, working_register_q}, {5'h0, op[2:0]});
            chk({7'h0, indirect_pointer_register_q}, {7'h0, op[0]});
            // bounded wait: a stuck counter must not hang the run
            while (done_q !== 1'b1 && k < 8)
            begin
                @(negedge mclk);
                k++;
            end
            chk(k[7:0], {5'h0, n});
            chk({7'h0, busy_q}, 8'h00);
        end
    endtask

    // operand modes of the last decode; they hold until the next take
    task md(input logic [2:0] s, input logic [2:0] d);
        begin
            chk({5'h0, src_mode_q}, {5'h0, s});
            chk({5'h0, dst_mode_q}, {5'h0, d});
        end
    endtask

    // eight consecutive register forms
    task r8(input logic [7:0] b, input logic [4:0] c, input logic [1:0] l, input logic [2:0] n);
        int i;
        begin
            for (i = 0; i < 8; i++)
                dec(b + i[7:0], c, l, n);
        end
    endtask

    // register, direct, indirect and optional fourth-column form of one row
    task grp(input logic [3:0] h, input logic [4:0] c, input logic [1:0] l4);
        begin
            r8({h, 4'h8}, c, 2'h1, 3'h1);
            dec({h, 4'h5}, c, 2'h2, 3'h1);
            dec({h, 4'h6}, c, 2'h1, 3'h1);
            dec({h, 4'h7}, c, 2'h1, 3'h1);
            if (l4 != 2'h0)
                dec({h, 4'h4}, c, l4, 3'h1);
        end
    endtask

    task t_reset_values;
        begin
            chk({busy_q, done_q, dec_valid_q, known_q, 4'h0}, 8'h00);
            chk({op_class_q, op_cycles_q}, {5'h00, 3'h1});
            chk({6'h0, op_len_q}, 8'h01);
            chk({src_mode_q, dst_mode_q, indirect_pointer_register_q, 1'b0}, 8'h00);
            chk({5'h0, working_register_q}, 8'h00);
        end
    endtask

    task t_arith;
        begin
            grp(4'h2, `MCD_OP_ADD, 2'h2);
            dec(8'h25, `MCD_OP_ADD, 2'h2, 3'h1);
            md(`MCD_M_DIR, `MCD_M_ACC);
            dec(8'h26, `MCD_OP_ADD, 2'h1, 3'h1);
            md(`MCD_M_IND, `MCD_M_ACC);
            dec(8'h24, `MCD_OP_ADD, 2'h2, 3'h1);
            md(`MCD_M_IMM, `MCD_M_ACC);
            grp(4'h3, `MCD_OP_ADD_WITH_CARRY, 2'h2);
            grp(4'h9, `MCD_OP_SUBTRACT_WITH_BORROW, 2'h2);
            grp(4'h0, `MCD_OP_INC, 2'h1);
            dec(8'ha3, `MCD_OP_INC_DP, 2'h1, 3'h2);
            grp(4'h1, `MCD_OP_DEC, 2'h1);
            dec(8'ha4, `MCD_OP_MUL, 2'h1, 3'h4);
            dec(8'h84, `MCD_OP_DIV, 2'h1, 3'h4);
            dec(8'hd4, `MCD_OP_DEC_ADJ, 2'h1, 3'h1);
        end
    endtask

    task t_logic;
        begin
            grp(4'h5, `MCD_OP_AND, 2'h2);
            dec(8'h52, `MCD_OP_AND, 2'h2, 3'h1);
            dec(8'h53, `MCD_OP_AND, 2'h3, 3'h2);
            grp(4'h4, `MCD_OP_OR, 2'h2);
            dec(8'h42, `MCD_OP_OR, 2'h2, 3'h1);
            dec(8'h43, `MCD_OP_OR, 2'h3, 3'h2);
            grp(4'h6, `MCD_OP_XOR, 2'h2);
            dec(8'h62, `MCD_OP_XOR, 2'h2, 3'h1);
            dec(8'h63, `MCD_OP_XOR, 2'h3, 3'h2);
            dec(8'h23, `MCD_OP_ROT_L, 2'h1, 3'h1);
            dec(8'h33, `MCD_OP_ROT_LC, 2'h1, 3'h1);
            dec(8'h03, `MCD_OP_ROT_R, 2'h1, 3'h1);
            dec(8'h13, `MCD_OP_ROT_RC, 2'h1, 3'h1);
            dec(8'hc4, `MCD_OP_SWAP, 2'h1, 3'h1);
            dec(8'he4, `MCD_OP_CLR, 2'h1, 3'h1);
            dec(8'hf4, `MCD_OP_CPL, 2'h1, 3'h1);
        end
    endtask

    task t_moves;
        begin
            grp(4'he, `MCD_OP_MOVE, 2'h0);
            dec(8'h74, `MCD_OP_MOVE, 2'h2, 3'h1);
            grp(4'hf, `MCD_OP_MOVE, 2'h0);
            md(`MCD_M_ACC, `MCD_M_IND);
            r8(8'ha8, `MCD_OP_MOVE, 2'h2, 3'h2);
            r8(8'h88, `MCD_OP_MOVE, 2'h2, 3'h2);
            r8(8'h78, `MCD_OP_MOVE, 2'h2, 3'h1);
            md(`MCD_M_IMM, `MCD_M_WREG);
            // pointer forms next to the register rows
            dec(8'h76, `MCD_OP_MOVE, 2'h2, 3'h1);
            md(`MCD_M_IMM, `MCD_M_IND);
            dec(8'h87, `MCD_OP_MOVE, 2'h2, 3'h2);
            md(`MCD_M_IND, `MCD_M_DIR);
            dec(8'ha7, `MCD_OP_MOVE, 2'h2, 3'h2);
            md(`MCD_M_DIR, `MCD_M_IND);
            dec(8'h85, `MCD_OP_MOVE, 2'h3, 3'h2);
            md(`MCD_M_DIR, `MCD_M_DIR);
            dec(8'h75, `MCD_OP_MOVE, 2'h3, 3'h2);
            md(`MCD_M_IMM, `MCD_M_DIR);
            dec(8'h90, `MCD_OP_LOAD_DP, 2'h3, 3'h2);
            dec(8'he2, `MCD_OP_EXTERNAL_DATA_MOVE, 2'h1, 3'h2);
            dec(8'he3, `MCD_OP_EXTERNAL_DATA_MOVE, 2'h1, 3'h2);
            dec(8'hf2, `MCD_OP_EXTERNAL_DATA_MOVE, 2'h1, 3'h2);
            dec(8'hf3, `MCD_OP_EXTERNAL_DATA_MOVE, 2'h1, 3'h2);
            dec(8'he0, `MCD_OP_EXTERNAL_DATA_MOVE, 2'h1, 3'h2);
            dec(8'hf0, `MCD_OP_EXTERNAL_DATA_MOVE, 2'h1, 3'h2);
            dec(8'h93, `MCD_OP_CODE_MEMORY_READ, 2'h1, 3'h2);
            md(`MCD_M_CODE, `MCD_M_ACC);
            dec(8'h83, `MCD_OP_CODE_MEMORY_READ, 2'h1, 3'h2);
            dec(8'hc0, `MCD_OP_PUSH, 2'h2, 3'h2);
            dec(8'hd0, `MCD_OP_POP, 2'h2, 3'h2);
            grp(4'hc, `MCD_OP_XCH, 2'h0);
            dec(8'hd6, `MCD_OP_LOW_NIBBLE_EXCHANGE, 2'h1, 3'h1);
            dec(8'hd7, `MCD_OP_LOW_NIBBLE_EXCHANGE, 2'h1, 3'h1);
        end
    endtask

    // request held through a four-cycle multiply is taken only after done
    task t_refuse;
        begin
            op_valid = 1'b1;
            op_byte = 8'ha4;
            @(negedge mclk);
            op_byte = 8'h04;
            repeat (4)
            begin
                @(negedge mclk);
                chk({dec_valid_q, 2'h0, op_class_q}, {3'h0, `MCD_OP_MUL});
            end
            chk({7'h0, done_q}, 8'h01);
            @(negedge mclk);
            op_valid = 1'b0;
            chk({dec_valid_q, 2'h0, op_class_q}, {3'h4, `MCD_OP_INC});
            @(negedge mclk);
            chk({7'h0, done_q}, 8'h01);
        end
    endtask

    // reset in mid-multiply drops busy and clears the fields
    task t_mid_reset;
        begin
            op_valid = 1'b1;
            op_byte = 8'ha4;
            @(negedge mclk);
            op_valid = 1'b0;
            resetn = 1'b0;
            @(negedge mclk);
            resetn = 1'b1;
            t_reset_values;
            // let the release edge pass before the next opcode
            @(negedge mclk);
            dec(8'h24, `MCD_OP_ADD, 2'h2, 3'h1);
        end
    endtask

    // branch, bit and unused codes fall outside the decoded groups
    task t_unknown;
        begin
            dec(8'h00, `MCD_OP_OTHER, 2'h1, 3'h1);
            dec(8'h80, `MCD_OP_OTHER, 2'h1, 3'h1);
            dec(8'hb5, `MCD_OP_OTHER, 2'h1, 3'h1);
            dec(8'ha5, `MCD_OP_OTHER, 2'h1, 3'h1);
        end
    endtask

    // main sequence, inputs driven on falling edges
    initial
    begin
        repeat (20) @(negedge mclk);
        resetn = 1'b1;
        @(negedge mclk);
        t_reset_values;
        t_arith;
        t_logic;
        t_moves;
        t_refuse;
        t_mid_reset;
        t_unknown;
        tally_and_finish;
    end

    // watchdog, far beyond the roughly 470 cycles the tests need
    initial
    begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        tally_and_finish;
    end
endmodule
`default_nettype wire
